/* File: shared/dmapod_pkg.sv */
// package for the dma parameter options decode block: offsets, fields, resets, states
`default_nettype none
package dmapod_pkg;

    // register byte offsets on the plain register port
    localparam logic [7:0]  DMAPOD_OFF_OPTIONS = 8'h00;
    localparam logic [7:0]  DMAPOD_OFF_SRC     = 8'h04;
    localparam logic [7:0]  DMAPOD_OFF_DST     = 8'h08;
    localparam logic [7:0]  DMAPOD_OFF_COUNTS  = 8'h0c;
    localparam logic [7:0]  DMAPOD_OFF_STATUS  = 8'h10;

    // option field positions
    localparam int          DMAPOD_BIT_SRC_MODE   = 0;
    localparam int          DMAPOD_BIT_DST_MODE   = 1;
    localparam int          DMAPOD_BIT_SYNC_DIM   = 2;
    localparam int          DMAPOD_BIT_FIXED_SET  = 3;
    localparam int          DMAPOD_FIFO_WIDTH_CODE_LSB       = 8;
    localparam int          DMAPOD_BIT_CMPL_POINT = 11;
    localparam int          DMAPOD_CODE_LSB       = 12;

    // counts register layout: first dimension low half, second dimension high half
    localparam int          DMAPOD_FIRST_DIM_BYTE_COUNT_LSB = 0;
    localparam int          DMAPOD_SECOND_DIM_ARRAY_COUNT_LSB = 16;

    // status register layout
    localparam int          DMAPOD_ST_ALIGN   = 0;
    localparam int          DMAPOD_ST_INVALID = 1;
    localparam int          DMAPOD_ST_NULL    = 2;
    localparam int          DMAPOD_ST_BUSY    = 3;
    localparam int          DMAPOD_ST_LINK    = 4;

    // fifo width codes and the largest legal one
    localparam logic [2:0]  DMAPOD_FIFO_WIDTH_CODE_MAX = 3'h5;

    // low address bits that must be clear in constant mode
    localparam logic [4:0]  DMAPOD_ALIGN_MASK = 5'h1f;

    // values after reset
    localparam logic [31:0] DMAPOD_RST_OPTIONS = 32'h0000_0000;
    localparam logic [31:0] DMAPOD_RST_ADDR    = 32'h0000_0000;
    localparam logic [15:0] DMAPOD_RST_COUNT   = 16'h0000;

    // one-cycle latency of read data, in cycles
    localparam int          DMAPOD_READ_LATENCY = 1;

    typedef enum logic [0:0] {
        DMAPOD_IDLE,
        DMAPOD_WALK
    } dmapod_state_t;

endpackage : dmapod_pkg
`default_nettype wire

/* File: verilog/dmapod_top.sv */
// dma parameter options decode: parameter set registers, request submission, address walk
`default_nettype none
module dmapod_top
    import dmapod_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_clk_en,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [31:0]       o_reg_rdata,
    input  wire logic              i_event,
    output logic                   o_tr_valid,
    output logic      [31:0]       o_tr_src,
    output logic      [31:0]       o_tr_dst,
    output logic      [15:0]       o_tr_first_dim_byte_count,
    output logic      [15:0]       o_tr_second_dim_array_count,
    output logic      [31:0]       o_tr_options,
    output logic                   o_addr_valid,
    input  wire logic              i_addr_ready,
    output logic      [31:0]       o_src_addr,
    output logic      [31:0]       o_dst_addr,
    output logic                   o_cmpl_valid,
    output logic      [5:0]        o_cmpl_code,
    output logic                   o_link_req,
    output logic                   o_busy
);

    typedef struct packed {
        dmapod_state_t state;
        logic [31:0]   options;
        logic [31:0]   src;
        logic [31:0]   dst;
        logic [15:0]   first_dim_byte_count;
        logic [15:0]   second_dim_array_count;
        logic          err_align;
        logic          err_invalid;
        logic          null_seen;
        logic          link_seen;
        logic [31:0]   rdata;
        logic          tr_valid;
        logic [31:0]   tr_src;
        logic [31:0]   tr_dst;
        logic [15:0]   tr_first_dim_byte_count;
        logic [15:0]   tr_second_dim_array_count;
        logic [31:0]   tr_options;
        logic [15:0]   byte_off;
        logic [15:0]   arrays_left;
        logic          addr_valid;
        logic [31:0]   src_addr;
        logic [31:0]   dst_addr;
        logic          cmpl_valid;
        logic [5:0]    cmpl_code;
        logic          link_req;
        logic          busy;
    } dmapod_regs_t;

    dmapod_regs_t q;
    dmapod_regs_t next_q;

    // fifo width in bytes for a code; reserved codes give zero
    function automatic logic [5:0] dmapod_fifo_bytes(input logic [2:0] code);
        logic [5:0] bytes;
        bytes = 6'h00;
        unique case (code)
            3'h0:    bytes = 6'h01;
            3'h1:    bytes = 6'h02;
            3'h2:    bytes = 6'h04;
            3'h3:    bytes = 6'h08;
            3'h4:    bytes = 6'h10;
            3'h5:    bytes = 6'h20;
            default: bytes = 6'h00;
        endcase
        return bytes;
    endfunction

    // address of one byte inside an array; width is a power of two so the modulo is a mask
    function automatic logic [31:0] dmapod_byte_addr(
        input logic [31:0] start,
        input logic [15:0] off,
        input logic        const_mode,
        input logic [2:0]  code
    );
        logic [5:0] mask;
        mask = dmapod_fifo_bytes(code) - 6'h01;
        if (const_mode)
        begin
            return start + {26'h0000000, off[5:0] & mask};
        end
        return start + {16'h0000, off};
    endfunction

    // constant-mode start address with any low bit set
    function automatic logic dmapod_misaligned(input logic [31:0] a, input logic const_mode);
        return const_mode && ((a[4:0] & DMAPOD_ALIGN_MASK) != 5'h00);
    endfunction

    logic       opt_src_const;
    logic       opt_dst_const;
    logic       opt_sync_ab;
    logic       opt_fixed;
    logic       opt_early;
    logic [2:0] opt_fifo_width_code;
    logic [5:0] opt_code;
    logic       w_src_const;
    logic       w_dst_const;
    logic [2:0] w_fifo_width_code;

    // live option decode; bits 7-4 are stored but steer nothing
    assign opt_src_const = q.options[DMAPOD_BIT_SRC_MODE];
    assign opt_dst_const = q.options[DMAPOD_BIT_DST_MODE];
    assign opt_sync_ab   = q.options[DMAPOD_BIT_SYNC_DIM];
    assign opt_fixed     = q.options[DMAPOD_BIT_FIXED_SET];
    assign opt_early     = q.options[DMAPOD_BIT_CMPL_POINT];
    assign opt_fifo_width_code      = q.options[DMAPOD_FIFO_WIDTH_CODE_LSB +: 3];
    assign opt_code      = q.options[DMAPOD_CODE_LSB +: 6];

    // walk uses the options captured at submission, so software may reprogram meanwhile
    assign w_src_const = q.tr_options[DMAPOD_BIT_SRC_MODE];
    assign w_dst_const = q.tr_options[DMAPOD_BIT_DST_MODE];
    assign w_fifo_width_code      = q.tr_options[DMAPOD_FIFO_WIDTH_CODE_LSB +: 3];

    // next-state logic for the whole block
    always_comb
    begin
        logic any_const;
        logic bad_align;
        logic bad_width;
        logic is_null;
        logic adv;
        logic last_byte;
        logic set_align;
        logic set_invalid;
        logic set_null;
        logic set_link;
        any_const   = 1'b0;
        bad_align   = 1'b0;
        bad_width   = 1'b0;
        is_null     = 1'b0;
        adv         = 1'b0;
        last_byte   = 1'b0;
        set_align   = 1'b0;
        set_invalid = 1'b0;
        set_null    = 1'b0;
        set_link    = 1'b0;
        next_q      = q;

        // single-cycle strobes fall back by default
        next_q.tr_valid   = 1'b0;
        next_q.cmpl_valid = 1'b0;
        next_q.link_req   = 1'b0;

        // checks of the set as it stands when an event arrives
        any_const = opt_src_const || opt_dst_const;
        bad_align = dmapod_misaligned(q.src, opt_src_const)
                 || dmapod_misaligned(q.dst, opt_dst_const);
        bad_width = any_const && (opt_fifo_width_code > DMAPOD_FIFO_WIDTH_CODE_MAX);
        is_null   = (q.first_dim_byte_count == 16'h0000) || (q.second_dim_array_count == 16'h0000);

        unique case (q.state)
            DMAPOD_IDLE:
            begin
                // events while a walk is running are not queued
                if (i_event)
                begin
                    if (bad_align)
                    begin
                        set_align = 1'b1;
                    end
                    else if (bad_width)
                    begin
                        set_invalid = 1'b1;
                    end
                    else if (is_null)
                    begin
                        set_null = 1'b1;
                    end
                    else
                    begin
                        next_q.tr_valid    = 1'b1;
                        next_q.tr_src      = q.src;
                        next_q.tr_dst      = q.dst;
                        next_q.tr_first_dim_byte_count     = q.first_dim_byte_count;
                        next_q.tr_second_dim_array_count     = opt_sync_ab ? q.second_dim_array_count : 16'h0001;
                        next_q.tr_options  = q.options;
                        next_q.byte_off    = 16'h0000;
                        next_q.arrays_left = opt_sync_ab ? q.second_dim_array_count : 16'h0001;
                        next_q.state       = DMAPOD_WALK;
                        if (opt_early)
                        begin
                            next_q.cmpl_valid = 1'b1;
                            next_q.cmpl_code  = opt_code;
                        end
                        // set update after submission unless the set is fixed
                        if (!opt_fixed)
                        begin
                            if (opt_sync_ab || (q.second_dim_array_count == 16'h0001))
                            begin
                                next_q.second_dim_array_count     = 16'h0000;
                                next_q.link_req = 1'b1;
                                set_link        = 1'b1;
                            end
                            else
                            begin
                                next_q.second_dim_array_count = q.second_dim_array_count - 16'h0001;
                            end
                        end
                    end
                end
            end
            DMAPOD_WALK:
            begin
                // a held address waits for the sink; nothing is dropped
                adv = !q.addr_valid || i_addr_ready;
                if (adv)
                begin
                    if (q.arrays_left != 16'h0000)
                    begin
                        next_q.addr_valid = 1'b1;
                        next_q.src_addr   = dmapod_byte_addr(q.tr_src, q.byte_off,
                                                             w_src_const, w_fifo_width_code);
                        next_q.dst_addr   = dmapod_byte_addr(q.tr_dst, q.byte_off,
                                                             w_dst_const, w_fifo_width_code);
                        last_byte = (q.byte_off == (q.tr_first_dim_byte_count - 16'h0001));
                        if (last_byte)
                        begin
                            // array index fields are outside this block, arrays restart at start
                            next_q.byte_off    = 16'h0000;
                            next_q.arrays_left = q.arrays_left - 16'h0001;
                        end
                        else
                        begin
                            next_q.byte_off = q.byte_off + 16'h0001;
                        end
                    end
                    else
                    begin
                        next_q.addr_valid = 1'b0;
                        next_q.state      = DMAPOD_IDLE;
                        if (!q.tr_options[DMAPOD_BIT_CMPL_POINT])
                        begin
                            next_q.cmpl_valid = 1'b1;
                            next_q.cmpl_code  = q.tr_options[DMAPOD_CODE_LSB +: 6];
                        end
                    end
                end
            end
        endcase

        // register writes; a write of a count in the update cycle overrides the update
        if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                ADDR_W'(DMAPOD_OFF_OPTIONS): next_q.options = i_reg_wdata;
                ADDR_W'(DMAPOD_OFF_SRC):     next_q.src     = i_reg_wdata;
                ADDR_W'(DMAPOD_OFF_DST):     next_q.dst     = i_reg_wdata;
                ADDR_W'(DMAPOD_OFF_COUNTS):
                begin
                    next_q.first_dim_byte_count = i_reg_wdata[DMAPOD_FIRST_DIM_BYTE_COUNT_LSB +: 16];
                    next_q.second_dim_array_count = i_reg_wdata[DMAPOD_SECOND_DIM_ARRAY_COUNT_LSB +: 16];
                end
                ADDR_W'(DMAPOD_OFF_STATUS):
                begin
                    // write one to clear sticky flags
                    next_q.err_align   = q.err_align && !i_reg_wdata[DMAPOD_ST_ALIGN];
                    next_q.err_invalid = q.err_invalid && !i_reg_wdata[DMAPOD_ST_INVALID];
                    next_q.null_seen   = q.null_seen && !i_reg_wdata[DMAPOD_ST_NULL];
                    next_q.link_seen   = q.link_seen && !i_reg_wdata[DMAPOD_ST_LINK];
                end
                default: ;
            endcase
        end

        // a flag raised in the same cycle as its clear stays set
        next_q.err_align   = next_q.err_align || set_align;
        next_q.err_invalid = next_q.err_invalid || set_invalid;
        next_q.null_seen   = next_q.null_seen || set_null;
        next_q.link_seen   = next_q.link_seen || set_link;

        // busy gets its own flop so the output needs no decode
        next_q.busy = (next_q.state == DMAPOD_WALK);

        // read data stand the cycle after the strobe only; unmapped reads give zero
        next_q.rdata = 32'h0000_0000;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                ADDR_W'(DMAPOD_OFF_OPTIONS): next_q.rdata = q.options;
                ADDR_W'(DMAPOD_OFF_SRC):     next_q.rdata = q.src;
                ADDR_W'(DMAPOD_OFF_DST):     next_q.rdata = q.dst;
                ADDR_W'(DMAPOD_OFF_COUNTS):  next_q.rdata = {q.second_dim_array_count, q.first_dim_byte_count};
                ADDR_W'(DMAPOD_OFF_STATUS):
                begin
                    next_q.rdata[DMAPOD_ST_ALIGN]   = q.err_align;
                    next_q.rdata[DMAPOD_ST_INVALID] = q.err_invalid;
                    next_q.rdata[DMAPOD_ST_NULL]    = q.null_seen;
                    next_q.rdata[DMAPOD_ST_BUSY]    = (q.state == DMAPOD_WALK);
                    next_q.rdata[DMAPOD_ST_LINK]    = q.link_seen;
                end
                default: next_q.rdata = 32'h0000_0000;
            endcase
        end
    end

    // all state in one register; clock enable freezes everything
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q             <= '0;
            q.state       <= DMAPOD_IDLE;
            q.options     <= DMAPOD_RST_OPTIONS;
            q.src         <= DMAPOD_RST_ADDR;
            q.dst         <= DMAPOD_RST_ADDR;
            q.first_dim_byte_count        <= DMAPOD_RST_COUNT;
            q.second_dim_array_count        <= DMAPOD_RST_COUNT;
        end
        else if (i_clk_en)
        begin
            q <= next_q;
        end
    end

    // outputs come straight from the state register
    assign o_reg_rdata  = q.rdata;
    assign o_tr_valid   = q.tr_valid;
    assign o_tr_src     = q.tr_src;
    assign o_tr_dst     = q.tr_dst;
    assign o_tr_first_dim_byte_count    = q.tr_first_dim_byte_count;
    assign o_tr_second_dim_array_count    = q.tr_second_dim_array_count;
    assign o_tr_options = q.tr_options;
    assign o_addr_valid = q.addr_valid;
    assign o_src_addr   = q.src_addr;
    assign o_dst_addr   = q.dst_addr;
    assign o_cmpl_valid = q.cmpl_valid;
    assign o_cmpl_code  = q.cmpl_code;
    assign o_link_req   = q.link_req;
    assign o_busy       = q.busy;

endmodule // dmapod_top
`default_nettype wire

/* File: tb/dmapod_sink.sv */
// far-side sink model: accepts address pairs, promptly or with random stalls
`default_nettype none
module dmapod_sink (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    input  wire logic i_slow,
    input  wire logic i_addr_valid,
    output logic      o_addr_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    // a slow sink drops ready at random so held pairs get exercised
    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_addr_ready <= 1'b0;
        else
            o_addr_ready <= !i_slow || ($urandom % 3 == 0);
    end
endmodule // dmapod_sink
`default_nettype wire

/* File: tb/dmapod_props.sv */
// assertion checker for the dma parameter options decode block
`default_nettype none
module dmapod_props (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic        i_clk_en,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_tr_valid,
    input wire logic [31:0] o_tr_src,
    input wire logic [31:0] o_tr_dst,
    input wire logic [15:0] o_tr_first_dim_byte_count,
    input wire logic [15:0] o_tr_second_dim_array_count,
    input wire logic [31:0] o_tr_options,
    input wire logic        o_addr_valid,
    input wire logic        i_addr_ready,
    input wire logic [31:0] o_src_addr,
    input wire logic [31:0] o_dst_addr,
    input wire logic        o_cmpl_valid,
    input wire logic [5:0]  o_cmpl_code,
    input wire logic        o_link_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // a frozen clock enable stalls everything, so attempts across it are dropped
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b || !i_clk_en);

    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_addr_follows: assert property (o_tr_valid |=> o_addr_valid &&
        o_src_addr == o_tr_src && o_dst_addr == o_tr_dst)
        else $error("first address pair does not follow request");
    a_pair_held: assert property (o_addr_valid && !i_addr_ready |=> o_addr_valid
        && $stable(o_src_addr) && $stable(o_dst_addr))
        else $error("address pair changed while stalled");
    a_early_cmpl: assert property (o_tr_valid |-> o_cmpl_valid == o_tr_options[11])
        else $error("completion at submission wrong");
    a_normal_cmpl: assert property ($fell(o_addr_valid) |->
        o_cmpl_valid == !o_tr_options[11])
        else $error("completion after last pair wrong");
    a_cmpl_code: assert property (o_cmpl_valid |-> o_cmpl_code == o_tr_options[17:12])
        else $error("completion code wrong");
    a_link_only: assert property (o_link_req |-> o_tr_valid && !o_tr_options[3])
        else $error("link request from fixed set");
    a_one_array: assert property (o_tr_valid && !o_tr_options[2] |-> o_tr_second_dim_array_count == 16'h1)
        else $error("array count not one");
    a_align_ok: assert property (o_tr_valid |-> !(o_tr_options[0] && |o_tr_src[4:0])
        && !(o_tr_options[1] && |o_tr_dst[4:0]))
        else $error("misaligned constant request submitted");
    a_width_legal: assert property (o_tr_valid && |o_tr_options[1:0] |->
        o_tr_options[10:8] <= 3'h5)
        else $error("reserved width submitted");
    a_src_wrap: assert property (o_addr_valid && o_tr_options[0] |->
        o_src_addr[31:5] == o_tr_src[31:5]
        && o_src_addr[4:0] < (6'h1 << o_tr_options[10:8]))
        else $error("source outside fifo width");
    a_dst_step: assert property (o_addr_valid && !o_tr_options[1] |->
        o_dst_addr - o_tr_dst < {16'h0, o_tr_first_dim_byte_count})
        else $error("destination outside array");
endmodule // dmapod_props

bind dmapod_top dmapod_props dmapod_props_inst (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_tr_valid(o_tr_valid), .o_tr_src(o_tr_src),
    .o_tr_dst(o_tr_dst), .o_tr_first_dim_byte_count(o_tr_first_dim_byte_count), .o_tr_second_dim_array_count(o_tr_second_dim_array_count),
    .o_tr_options(o_tr_options), .o_addr_valid(o_addr_valid), .i_addr_ready(i_addr_ready),
    .o_src_addr(o_src_addr), .o_dst_addr(o_dst_addr), .o_cmpl_valid(o_cmpl_valid),
    .o_cmpl_code(o_cmpl_code), .o_link_req(o_link_req)
);
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking testbench for the dma parameter options decode block
`default_nettype none
module testbench
    import dmapod_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [7:0]       addr = 8'h0;
    logic [31:0]      wdata = 32'h0;
    logic             wr = 1'b0, rd = 1'b0, ev = 1'b0, slow = 1'b0, rd_p = 1'b0;
    wire logic [31:0] rdata, tr_src, tr_dst, tr_opt, src_a, dst_a;
    wire logic [15:0] tr_first_dim_byte_count, tr_second_dim_array_count;
    wire logic [5:0]  code;
    wire logic        tr_v, a_v, a_rdy, c_v, link, busy;
    int               fail_count = 0;
    int               n_tests = 0;
    logic [31:0]      rq[$];
    logic [63:0]      aq[$];
    logic [128:0]     tq[$];
    logic [5:0]       cq[$];

    always #2.5 clk = ~clk;

    dmapod_top #(.ADDR_W(8)) dmapod_top_inst (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_event(ev), .o_tr_valid(tr_v), .o_tr_src(tr_src), .o_tr_dst(tr_dst),
        .o_tr_first_dim_byte_count(tr_first_dim_byte_count), .o_tr_second_dim_array_count(tr_second_dim_array_count), .o_tr_options(tr_opt),
        .o_addr_valid(a_v), .i_addr_ready(a_rdy), .o_src_addr(src_a), .o_dst_addr(dst_a),
        .o_cmpl_valid(c_v), .o_cmpl_code(code), .o_link_req(link), .o_busy(busy)
    );
    dmapod_sink dmapod_sink_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_slow(slow),
        .i_addr_valid(a_v), .o_addr_ready(a_rdy));

    task automatic chk(input logic [159:0] e, input logic [159:0] g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic end_sim();
        $display("TB: tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // outputs are matched at mid-cycle, once every edge update has landed
    always @(posedge clk)
        rd_p <= rd && rst_b;
    always @(negedge clk)
    begin
        if (rd_p)
            chk(rq.size() ? rq.pop_front() : 'x, rdata);
        // an unknown strobe still triggers a compare, which then fails
        if (tr_v !== 1'b0)
            chk(tq.size() ? tq.pop_front() : 'x,
                {tr_src, tr_dst, tr_first_dim_byte_count, tr_second_dim_array_count, tr_opt, link});
        if ((a_v && a_rdy) !== 1'b0)
            chk(aq.size() ? aq.pop_front() : 'x, {src_a, dst_a});
        if (c_v !== 1'b0)
            chk(cq.size() ? cq.pop_front() : 'x, code);
    end

    // program a set, fire an event (and, when again is set, a second one while busy), check the outcome
    task automatic run(input logic [31:0] channel_transfer_options, input logic [31:0] s, input logic [31:0] d,
                       input logic [15:0] ac, input logic [15:0] bc, input logic again);
        logic [31:0] st;
        logic [15:0] nb;
        int          w;
        int          i;
        st = 32'h0;
        nb = channel_transfer_options[2] ? bc : 16'h1;
        w = 1 << channel_transfer_options[10:8];
        wreg(DMAPOD_OFF_OPTIONS, channel_transfer_options);
        wreg(DMAPOD_OFF_SRC, s);
        wreg(DMAPOD_OFF_DST, d);
        wreg(DMAPOD_OFF_COUNTS, {bc, ac});
        if ((channel_transfer_options[0] && s[4:0] != 5'h0) || (channel_transfer_options[1] && d[4:0] != 5'h0))
            st = 32'h1;
        else if (channel_transfer_options[1:0] != 2'h0 && channel_transfer_options[10:8] > DMAPOD_FIFO_WIDTH_CODE_MAX)
            st = 32'h2;
        else if (ac == 16'h0 || bc == 16'h0)
            st = 32'h4;
        else
        begin
            tq.push_back({s, d, ac, nb, channel_transfer_options, !channel_transfer_options[3] && (channel_transfer_options[2] || bc == 16'h1)});
            for (i = 0; i < nb * ac; i++)
                aq.push_back({channel_transfer_options[0] ? s + (i % ac) % w : s + i % ac,
                              channel_transfer_options[1] ? d + (i % ac) % w : d + i % ac});
            cq.push_back(channel_transfer_options[17:12]);
            if (!channel_transfer_options[3] && (channel_transfer_options[2] || bc == 16'h1))
                st = 32'h10;
            if (!channel_transfer_options[3])
                bc = (channel_transfer_options[2] || bc == 16'h1) ? 16'h0 : bc - 16'h1;
        end
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= again;
        @(posedge clk);
        ev <= 1'b0;
        for (i = 0; i < 4000 && busy !== 1'b0; i++)
            @(negedge clk);
        if (busy !== 1'b0)
        begin
            fail_count++;
            end_sim();
        end
        rreg(DMAPOD_OFF_STATUS, st);
        rreg(DMAPOD_OFF_COUNTS, {bc, ac});
        wreg(DMAPOD_OFF_STATUS, 32'h1f);
        rreg(DMAPOD_OFF_STATUS, 32'h0);
        // every expected request, pair and completion must have shown up
        chk(160'h0, 160'(aq.size() + tq.size() + cq.size()));
        $display("TB: test done opt=%h", channel_transfer_options);
    endtask

    initial
    begin
        int          f;
        logic [31:0] r;
        r = $urandom(32'h62391503);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        // all registers and one unmapped place read zero after reset
        for (f = 0; f < 6; f++)
            rreg(8'(f * 4), 32'h0);
        $display("TB: test done reset values");
        r = $urandom & 32'hffff_ff00;
        run($urandom & 32'h3f000, r + 32'h7, r + 32'h4_1235, 16'h3, 16'h2, 1'b1);
        slow <= 1'b1;
        run(32'h2aa0d, r, r + 32'h105, 16'h6, 16'h2, 1'b1);
        run(32'h0502, r, r + 32'h10, 16'h4, 16'h1, 1'b0);
        run(32'h0601, r, r, 16'h4, 16'h1, 1'b0);
        run(32'h0000, r, r, 16'h0, 16'h3, 1'b0);
        run(32'h0000, r, r, 16'h5, 16'h0, 1'b0);
        run(32'h0704, r + 32'h1, r + 32'h2, 16'h2, 16'h3, 1'b0);
        // every legal width in constant mode on both sides, wrapping past 32 bytes
        for (f = 0; f < 6; f++)
        begin
            slow <= f[0];
            run((32'(f) << 8) | 32'h3, r, r + 32'h40, 16'd33, 16'h1, 1'b0);
        end
        end_sim();
    end
endmodule // testbench
`default_nettype wire
